// file: core/dcg_bus_if.sv
// Processor port from glue top to its counter blocks
`timescale 1ns/1ps
interface dcg_bus_if;
    logic [15:0] addr;
    logic        rd;
    logic        wr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    modport master (output addr, rd, wr, wdata, input rdata);
    modport slave  (input addr, rd, wr, wdata, output rdata);
endinterface

// file: core/dcg_consts.svh
// Address map, fields, reset values and timing of the glue
`ifndef DCG_CONSTS_SVH
`define DCG_CONSTS_SVH

`define DCG_CLK_HZ       10000000
`define DCG_CLK_NS       100
`define DCG_TICK_HZ      49
`define DCG_TICK_CYC     (`DCG_CLK_HZ / `DCG_TICK_HZ)
`define DCG_SETTLE_NS    10000
`define DCG_SETTLE_CYC   ((`DCG_SETTLE_NS + `DCG_CLK_NS - 1) / `DCG_CLK_NS)
`define DCG_CPU_RST_CYC  5'h10

`define DCG_CMD_MAX      16'h1FFF
`define DCG_RAM8_HI      16'h3FFF
`define DCG_IO_LO        16'h4000
`define DCG_IO_HI        16'h7FFF
`define DCG_VN_BASE      16'h8000

`define DCG_A_STAT       16'h4000
`define DCG_A_NORM       16'h4100
`define DCG_A_PROT       16'h4200
`define DCG_A_CRP_THR    16'h4300
`define DCG_A_CRP_INT    16'h4400
`define DCG_A_DOOR_TMO   16'h4500
`define DCG_A_MUX        16'h4600
`define DCG_A_ADC_LO     16'h4700
`define DCG_A_ADC_HI     16'h47FF
`define DCG_A_CMD_ADDR   16'h4800
`define DCG_A_CMD_DATA   16'h4802
`define DCG_A_CNT_LO     16'h6000
`define DCG_A_CNT_HI     16'h61FF
`define DCG_A_PHD_LO     16'h6200
`define DCG_A_PHD_HI     16'h63FF

`define DCG_P_HV_ON      0
`define DCG_P_HV_NOM     1
`define DCG_P_DOOR_RUN   2
`define DCG_P_DOOR_DIR   3
`define DCG_P_AUX_ON     4
`define DCG_N_CRP_EN     0
`define DCG_N_ILIM_EN    1

`define DCG_RST_CRP_THR  16'h0400
`define DCG_RST_CRP_INT  16'h0031
`define DCG_RST_DOOR_TMO 16'h0C40

`endif

// file: core/dcg_counters.sv
// Stage event counters, cleared by a read
`timescale 1ns/1ps
module dcg_counters (
    input  wire logic       i_mclk,
    input  wire logic       i_rst,
    input  wire logic [3:0] i_evt,
    dcg_bus_if.slave        bus
);
    logic [15:0] cnt_r [4];
    logic [15:0] rdata_r;
    logic [1:0]  idx;

    // Bit 8 picks the segment page, bit 1 the stage
    assign idx = {bus.addr[8], bus.addr[1]};
    assign bus.rdata = rdata_r;

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            for (int i = 0; i < 4; i++) begin
                cnt_r[i] <= 16'h0000;
            end
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (i_evt[i]) begin
                    cnt_r[i] <= (bus.rd && idx == 2'(i)) ? 16'h0001 : cnt_r[i] + 16'h0001;
                end else if (bus.rd && idx == 2'(i)) begin
                    cnt_r[i] <= 16'h0000;
                end
            end
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            rdata_r <= 16'h0000;
        end else if (bus.rd) begin
            rdata_r <= cnt_r[idx];
        end
    end
endmodule

// file: core/dcg_phd.sv
// Two 128-bin pulse height histograms
`timescale 1ns/1ps
module dcg_phd (
    input  wire logic       i_mclk,
    input  wire logic       i_rst,
    input  wire logic       i_ph_valid,
    input  wire logic       i_ph_seg,
    input  wire logic [6:0] i_ph_height,
    input  wire logic       i_ph_disable,
    dcg_bus_if.slave        bus
);
    logic [15:0] bin_r [256];
    logic [15:0] rdata_r;
    logic [7:0]  cpu_idx;
    logic [7:0]  evt_idx;

    assign cpu_idx   = bus.addr[8:1];
    assign evt_idx   = {i_ph_seg, i_ph_height};
    assign bus.rdata = rdata_r;

    // Reads never clear bins; software writes zeros
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            for (int i = 0; i < 256; i++) begin
                bin_r[i] <= 16'h0000;
            end
        end else if (bus.wr) begin
            bin_r[cpu_idx] <= bus.wdata;
        end else if (i_ph_valid && !i_ph_disable) begin
            bin_r[evt_idx] <= bin_r[evt_idx] + 16'h0001;
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            rdata_r <= 16'h0000;
        end else if (bus.rd) begin
            rdata_r <= bin_r[cpu_idx];
        end
    end
endmodule

// file: core/dcg_pkg.sv
// Types shared by the control glue modules
package dcg_pkg;
    typedef enum logic [1:0] {CRP_OFF, CRP_SAMPLE, CRP_HOLD} dcg_crp_t;
    typedef enum logic [1:0] {ADC_IDLE, ADC_SETTLE} dcg_adc_t;
    typedef enum logic [1:0] {SRC_LOC, SRC_CNT, SRC_PHD} dcg_src_t;
endpackage

// file: core/dcg_top.sv
// Detector control glue: command intake, decode, counters, controls, protection
// Behaviour
// - Full command word raises processor interrupt
// - Command data written at command address
// - Only addresses up to 0x1FFF are written
// - Events increment counters at each stage
// - Histogram of 128 16-bit bins
// - Separate histograms for segments A and B
// - Damaging controls only written under lock
// - Excess count rate forces reduced high voltage
// - Tick near 49 Hz, restarted on re-entry
// - Door timeout in ticks forces door stop
// - Any latch change forces door stop
// - Over-current reported, may cut power
// - Select input, settle, then capture converter
// - Processor restarts fetching at address zero
// - From 0x8000 up code and data share memory
// - Reading a counter clears it
`timescale 1ns/1ps
`include "dcg_consts.svh"
module dcg_top #(
    parameter int P_TICK_CYC = `DCG_TICK_CYC
) (
    input  wire logic        i_mclk,
    input  wire logic        i_rst,
    input  wire logic        i_cmd_valid,
    input  wire logic [31:0] i_cmd_word,
    input  wire logic [15:0] i_cpu_addr,
    input  wire logic        i_cpu_rd,
    input  wire logic        i_cpu_wr,
    input  wire logic        i_cpu_fetch,
    input  wire logic [15:0] i_cpu_wdata,
    input  wire logic        i_lock,
    input  wire logic        i_ph_disable,
    input  wire logic        i_main_reentry,
    input  wire logic [1:0]  i_evt_fast,
    input  wire logic [1:0]  i_evt_dig,
    input  wire logic        i_ph_valid,
    input  wire logic        i_ph_seg,
    input  wire logic [6:0]  i_ph_height,
    input  wire logic [7:0]  i_switches,
    input  wire logic        i_door_latch,
    input  wire logic        i_ilimit,
    input  wire logic [15:0] i_adc_data,
    output logic      [15:0] o_cpu_rdata,
    output logic             o_cpu_rvalid,
    output logic             o_cmd_irq,
    output logic             o_mem_we,
    output logic      [15:0] o_mem_addr,
    output logic      [15:0] o_mem_wdata,
    output logic             o_cmd_special,
    output logic             o_cpu_reset,
    output logic             o_prom_cs,
    output logic             o_ram8_cs,
    output logic             o_ram32_cs,
    output logic             o_io_cs,
    output logic      [7:0]  o_ctrl_norm,
    output logic      [7:0]  o_ctrl_prot,
    output logic             o_hv_reduced_state,
    output logic             o_tick,
    output logic             o_door_stop,
    output logic             o_ilimit_evt,
    output logic      [7:0]  o_mux_sel
);
    function automatic logic in_rng(input logic [15:0] a, input logic [15:0] lo,
                                    input logic [15:0] hi);
        return (a >= lo) && (a <= hi);
    endfunction

    logic              dat_rd;
    logic              dat_wr;
    logic [7:0]        prot_nxt;
    logic [15:0]       loc_data;
    logic [15:0]       loc_r;
    dcg_pkg::dcg_src_t src_r;
    logic              rd_d_r;
    logic [15:0]       cmd_addr_r;
    logic [15:0]       cmd_data_r;
    logic [17:0]       tick_cnt_r;
    logic [4:0]        rst_cnt_r;
    logic [15:0]       crp_thr_r;
    logic [15:0]       crp_int_r;
    logic [15:0]       door_tmo_r;
    logic [15:0]       door_left_r;
    logic              run_d_r;
    logic              latch_d_r;
    logic              latch_vld_r;
    logic              door_tmo;
    logic              latch_chg;
    logic              ilim_d_r;
    logic              ilim_off;
    dcg_pkg::dcg_crp_t crp_st_r;
    logic [15:0]       crp_cnt_r;
    logic [15:0]       crp_left_r;
    logic              crp_trig_r;
    dcg_pkg::dcg_adc_t adc_st_r;
    logic [6:0]        settle_r;
    logic [15:0]       adc_r;

    dcg_bus_if cnt_bus ();
    dcg_bus_if phd_bus ();

    assign dat_rd = i_cpu_rd && !i_cpu_fetch;
    assign dat_wr = i_cpu_wr && !i_cpu_fetch;

    assign cnt_bus.addr  = i_cpu_addr;
    assign cnt_bus.rd    = dat_rd && in_rng(i_cpu_addr, `DCG_A_CNT_LO, `DCG_A_CNT_HI);
    assign cnt_bus.wr    = 1'b0;
    assign cnt_bus.wdata = i_cpu_wdata;
    assign phd_bus.addr  = i_cpu_addr;
    assign phd_bus.rd    = dat_rd && in_rng(i_cpu_addr, `DCG_A_PHD_LO, `DCG_A_PHD_HI);
    assign phd_bus.wr    = dat_wr && in_rng(i_cpu_addr, `DCG_A_PHD_LO, `DCG_A_PHD_HI);
    assign phd_bus.wdata = i_cpu_wdata;

    dcg_counters u_cnt (
        .i_mclk (i_mclk),
        .i_rst  (i_rst),
        .i_evt  ({i_evt_dig[1], i_evt_fast[1], i_evt_dig[0], i_evt_fast[0]}),
        .bus    (cnt_bus)
    );

    dcg_phd u_phd (
        .i_mclk       (i_mclk),
        .i_rst        (i_rst),
        .i_ph_valid   (i_ph_valid),
        .i_ph_seg     (i_ph_seg),
        .i_ph_height  (i_ph_height),
        .i_ph_disable (i_ph_disable),
        .bus          (phd_bus)
    );

    // hold processor in reset, restart at zero
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            rst_cnt_r   <= 5'h00;
            o_cpu_reset <= 1'b1;
        end else if (rst_cnt_r != `DCG_CPU_RST_CYC) begin
            rst_cnt_r   <= rst_cnt_r + 5'h01;
            o_cpu_reset <= 1'b1;
        end else begin
            o_cpu_reset <= 1'b0;
        end
    end

    // shared upper memory for code and data
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_prom_cs  <= 1'b0;
            o_ram32_cs <= 1'b0;
            o_ram8_cs  <= 1'b0;
            o_io_cs    <= 1'b0;
        end else begin
            o_prom_cs  <= i_cpu_fetch && i_cpu_addr < `DCG_VN_BASE;
            o_ram32_cs <= (i_cpu_fetch || dat_rd || dat_wr) && i_cpu_addr >= `DCG_VN_BASE;
            o_ram8_cs  <= (dat_rd || dat_wr) && i_cpu_addr <= `DCG_RAM8_HI;
            o_io_cs    <= (dat_rd || dat_wr) && in_rng(i_cpu_addr, `DCG_IO_LO, `DCG_IO_HI);
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            cmd_addr_r    <= 16'h0000;
            cmd_data_r    <= 16'h0000;
            o_cmd_irq     <= 1'b0;
            o_mem_we      <= 1'b0;
            o_mem_addr    <= 16'h0000;
            o_mem_wdata   <= 16'h0000;
            o_cmd_special <= 1'b0;
        end else begin
            o_mem_we      <= 1'b0;
            o_cmd_special <= 1'b0;
            if (i_cmd_valid) begin
                cmd_addr_r <= i_cmd_word[31:16];
                cmd_data_r <= i_cmd_word[15:0];
                // interrupt, new word wins over ack
                o_cmd_irq  <= 1'b1;
                if (i_cmd_word[31:16] <= `DCG_CMD_MAX) begin
                    o_mem_we    <= 1'b1;
                    o_mem_addr  <= i_cmd_word[31:16];
                    o_mem_wdata <= i_cmd_word[15:0];
                end else begin
                    o_cmd_special <= 1'b1;
                end
            end else if (dat_rd && i_cpu_addr == `DCG_A_CMD_ADDR) begin
                o_cmd_irq <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            tick_cnt_r <= 18'h00000;
            o_tick     <= 1'b0;
        end else if (i_main_reentry) begin
            tick_cnt_r <= 18'h00000;
            o_tick     <= 1'b0;
        end else if (tick_cnt_r == 18'(P_TICK_CYC - 1)) begin
            tick_cnt_r <= 18'h00000;
            o_tick     <= 1'b1;
        end else begin
            tick_cnt_r <= tick_cnt_r + 18'h00001;
            o_tick     <= 1'b0;
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_ctrl_norm <= 8'h00;
            crp_thr_r   <= `DCG_RST_CRP_THR;
            crp_int_r   <= `DCG_RST_CRP_INT;
            door_tmo_r  <= `DCG_RST_DOOR_TMO;
        end else if (dat_wr) begin
            case (i_cpu_addr)
                `DCG_A_NORM:     o_ctrl_norm <= i_cpu_wdata[7:0];
                `DCG_A_CRP_THR:  crp_thr_r   <= i_cpu_wdata;
                `DCG_A_CRP_INT:  crp_int_r   <= i_cpu_wdata;
                `DCG_A_DOOR_TMO: door_tmo_r  <= i_cpu_wdata;
                default: ;
            endcase
        end
    end

    // Forcing beats a same-cycle software write
    always_comb begin
        prot_nxt = o_ctrl_prot;
        if (dat_wr && i_cpu_addr == `DCG_A_PROT && i_lock) begin
            prot_nxt = i_cpu_wdata[7:0];
        end
        if (door_tmo || latch_chg) begin
            prot_nxt[`DCG_P_DOOR_RUN] = 1'b0;
        end
        if (crp_trig_r) begin
            prot_nxt[`DCG_P_HV_NOM] = 1'b0;
        end
        if (ilim_off) begin
            prot_nxt[`DCG_P_HV_ON]  = 1'b0;
            prot_nxt[`DCG_P_AUX_ON] = 1'b0;
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_ctrl_prot        <= 8'h00;
            o_hv_reduced_state <= 1'b1;
            o_door_stop        <= 1'b0;
        end else begin
            o_ctrl_prot        <= prot_nxt;
            o_hv_reduced_state <= !prot_nxt[`DCG_P_HV_NOM];
            o_door_stop        <= door_tmo || latch_chg;
        end
    end

    // Compare latch after one sample: no false change at reset
    assign latch_chg = latch_vld_r && (i_door_latch != latch_d_r);
    assign door_tmo  = o_ctrl_prot[`DCG_P_DOOR_RUN] && run_d_r && door_left_r == 16'h0000;

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            run_d_r     <= 1'b0;
            door_left_r <= 16'h0000;
            latch_d_r   <= 1'b0;
            latch_vld_r <= 1'b0;
        end else begin
            run_d_r     <= o_ctrl_prot[`DCG_P_DOOR_RUN];
            latch_d_r   <= i_door_latch;
            latch_vld_r <= 1'b1;
            if (o_ctrl_prot[`DCG_P_DOOR_RUN] && !run_d_r) begin
                door_left_r <= door_tmo_r;
            end else if (o_tick && door_left_r != 16'h0000) begin
                door_left_r <= door_left_r - 16'h0001;
            end
        end
    end

    assign ilim_off = i_ilimit && o_ctrl_norm[`DCG_N_ILIM_EN];

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            ilim_d_r     <= 1'b0;
            o_ilimit_evt <= 1'b0;
        end else begin
            ilim_d_r     <= i_ilimit;
            o_ilimit_evt <= i_ilimit && !ilim_d_r;
        end
    end

    // count-rate protection over a window of crp_int_r ticks
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            crp_st_r   <= dcg_pkg::CRP_OFF;
            crp_cnt_r  <= 16'h0000;
            crp_left_r <= 16'h0000;
            crp_trig_r <= 1'b0;
        end else begin
            crp_trig_r <= 1'b0;
            case (crp_st_r)
                dcg_pkg::CRP_OFF: begin
                    crp_cnt_r  <= 16'h0000;
                    crp_left_r <= crp_int_r;
                    if (o_ctrl_norm[`DCG_N_CRP_EN]) begin
                        crp_st_r <= dcg_pkg::CRP_SAMPLE;
                    end
                end
                dcg_pkg::CRP_SAMPLE: begin
                    if (!o_ctrl_norm[`DCG_N_CRP_EN]) begin
                        crp_st_r <= dcg_pkg::CRP_OFF;
                    end else if (o_tick && crp_left_r <= 16'h0001) begin
                        crp_cnt_r  <= 16'h0000;
                        crp_left_r <= crp_int_r;
                        if (crp_cnt_r > crp_thr_r) begin
                            crp_trig_r <= 1'b1;
                            crp_st_r   <= dcg_pkg::CRP_HOLD;
                        end
                    end else begin
                        // Saturate so a burst cannot wrap away
                        if (crp_cnt_r < 16'hFFFE) begin
                            crp_cnt_r <= crp_cnt_r + {15'h0000, i_evt_fast[0]}
                                                   + {15'h0000, i_evt_fast[1]};
                        end
                        if (o_tick) begin
                            crp_left_r <= crp_left_r - 16'h0001;
                        end
                    end
                end
                dcg_pkg::CRP_HOLD: begin
                    if (!o_ctrl_norm[`DCG_N_CRP_EN]) begin
                        crp_st_r <= dcg_pkg::CRP_OFF;
                    end
                end
                default: crp_st_r <= dcg_pkg::CRP_OFF;
            endcase
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            adc_st_r  <= dcg_pkg::ADC_IDLE;
            settle_r  <= 7'h00;
            adc_r     <= 16'h0000;
            o_mux_sel <= 8'h00;
        end else begin
            case (adc_st_r)
                dcg_pkg::ADC_IDLE: begin
                    if (dat_wr && i_cpu_addr == `DCG_A_MUX) begin
                        o_mux_sel <= i_cpu_wdata[7:0];
                        settle_r  <= 7'(`DCG_SETTLE_CYC - 1);
                        adc_st_r  <= dcg_pkg::ADC_SETTLE;
                    end
                end
                dcg_pkg::ADC_SETTLE: begin
                    if (settle_r == 7'h00) begin
                        adc_r    <= i_adc_data;
                        adc_st_r <= dcg_pkg::ADC_IDLE;
                    end else begin
                        settle_r <= settle_r - 7'h01;
                    end
                end
                default: adc_st_r <= dcg_pkg::ADC_IDLE;
            endcase
        end
    end

    always_comb begin
        loc_data = 16'h0000;
        if (in_rng(i_cpu_addr, `DCG_A_ADC_LO, `DCG_A_ADC_HI)) begin
            loc_data = adc_r;
        end else begin
            case (i_cpu_addr)
                `DCG_A_STAT:     loc_data = {5'h00, o_cmd_irq, adc_st_r != dcg_pkg::ADC_IDLE,
                                             crp_st_r == dcg_pkg::CRP_HOLD, i_switches};
                `DCG_A_NORM:     loc_data = {8'h00, o_ctrl_norm};
                `DCG_A_PROT:     loc_data = {8'h00, o_ctrl_prot};
                `DCG_A_CRP_THR:  loc_data = crp_thr_r;
                `DCG_A_CRP_INT:  loc_data = crp_int_r;
                `DCG_A_DOOR_TMO: loc_data = door_tmo_r;
                `DCG_A_MUX:      loc_data = {8'h00, o_mux_sel};
                `DCG_A_CMD_ADDR: loc_data = cmd_addr_r;
                `DCG_A_CMD_DATA: loc_data = cmd_data_r;
                default:         loc_data = 16'h0000;
            endcase
        end
    end

    // Two-edge read path: outputs straight from flops
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            rd_d_r       <= 1'b0;
            src_r        <= dcg_pkg::SRC_LOC;
            loc_r        <= 16'h0000;
            o_cpu_rdata  <= 16'h0000;
            o_cpu_rvalid <= 1'b0;
        end else begin
            rd_d_r       <= dat_rd;
            loc_r        <= loc_data;
            o_cpu_rvalid <= rd_d_r;
            if (cnt_bus.rd) begin
                src_r <= dcg_pkg::SRC_CNT;
            end else if (phd_bus.rd) begin
                src_r <= dcg_pkg::SRC_PHD;
            end else begin
                src_r <= dcg_pkg::SRC_LOC;
            end
            if (rd_d_r) begin
                case (src_r)
                    dcg_pkg::SRC_CNT: o_cpu_rdata <= cnt_bus.rdata;
                    dcg_pkg::SRC_PHD: o_cpu_rdata <= phd_bus.rdata;
                    default:          o_cpu_rdata <= loc_r;
                endcase
            end
        end
    end
endmodule

// file: tb/dcg_host_model.sv
// Host electronics unit sending command words
`timescale 1ns/1ps
module dcg_host_model (
    input  wire logic        i_mclk,
    output logic             o_cmd_valid,
    output logic [31:0]      o_cmd_word
);
    initial begin
        o_cmd_valid = 1'b0;
        o_cmd_word  = '0;
    end
    // Idle word shows the inverse, not stale data
    task automatic send(input logic [31:0] w);
        @(posedge i_mclk);
        o_cmd_valid <= 1'b1;
        o_cmd_word  <= w;
        @(posedge i_mclk);
        o_cmd_valid <= 1'b0;
        o_cmd_word  <= ~w;
    endtask
endmodule

// file: tb/dcg_props.sv
// Port checker for the control glue
`timescale 1ns/1ps
module dcg_props #(parameter int P_TICK_CYC = 20) (
    input wire logic        i_mclk, i_rst, i_cmd_valid, i_cpu_rd, i_cpu_wr, i_cpu_fetch,
    input wire logic        i_lock, i_main_reentry, i_door_latch, i_ilimit,
    input wire logic [31:0] i_cmd_word,
    input wire logic [15:0] i_cpu_addr, o_mem_addr, o_mem_wdata,
    input wire logic [7:0]  o_ctrl_prot,
    input wire logic        o_cpu_rvalid, o_cmd_irq, o_mem_we, o_cmd_special, o_ram32_cs,
    input wire logic        o_hv_reduced_state, o_tick, o_ilimit_evt
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    a_cmd_irq_set:
    assert property (i_cmd_valid |=> o_cmd_irq) else $error("no irq");
    a_cmd_mem_write:
    assert property (i_cmd_valid && i_cmd_word[31:16] <= 16'h1FFF |=> o_mem_we
        && o_mem_addr == $past(i_cmd_word[31:16]) && o_mem_wdata == $past(i_cmd_word[15:0]))
        else $error("bad write");
    a_cmd_special_only:
    assert property (i_cmd_valid && i_cmd_word[31:16] > 16'h1FFF |=> o_cmd_special && !o_mem_we)
        else $error("reserved written");
    a_read_answer_time:
    assert property (i_cpu_rd && !i_cpu_fetch && i_cpu_addr[15:14] == 2'b01 |-> ##2 o_cpu_rvalid)
        else $error("late read");
    a_hv_reduced_level:
    assert property (o_hv_reduced_state == !o_ctrl_prot[1]) else $error("bad hv state");
    a_prot_needs_lock:
    assert property ((o_ctrl_prot & ~$past(o_ctrl_prot)) != 8'h00 |-> $past(i_lock)
        || $past(i_lock, 2)) else $error("unlocked set");
    a_tick_period_exact:
    assert property (disable iff (i_rst || i_main_reentry) o_tick |-> ##P_TICK_CYC o_tick)
        else $error("bad tick");
    a_latch_door_stop:
    assert property ($changed(i_door_latch) |-> ##[0:2] !o_ctrl_prot[2])
        else $error("no door stop");
    a_ilimit_event_out:
    assert property ($rose(i_ilimit) |-> ##[0:2] o_ilimit_evt) else $error("no ilimit event");
    a_upper_mem_select:
    assert property ((i_cpu_rd || i_cpu_wr) && i_cpu_addr[15] |=> o_ram32_cs)
        else $error("no ram32 select");
endmodule

// file: tb/detector_control_glue_tb_top.sv
// Bench for the detector control glue
`timescale 1ns/1ps
module detector_control_glue_tb_top;
    logic        i_mclk = '0, i_rst = '1, i_cpu_rd = '0, i_cpu_wr = '0, i_cpu_fetch = '0;
    logic        i_lock = '0, i_ph_disable = '0, i_main_reentry = '0, i_ph_valid = '0;
    logic        i_ph_seg = '0, i_door_latch = '0, i_ilimit = '0, i_cmd_valid;
    logic [1:0]  i_evt_fast = '0, i_evt_dig = '0;
    logic [6:0]  i_ph_height = '0;
    logic [7:0]  i_switches = 8'h5A;
    logic [15:0] i_cpu_addr = '0, i_cpu_wdata = '0, i_adc_data = 16'h1234, d;
    logic [31:0] i_cmd_word, w;
    logic        o_cpu_rvalid, o_cmd_irq, o_mem_we, o_cmd_special, o_cpu_reset, o_prom_cs;
    logic        o_ram8_cs, o_ram32_cs, o_io_cs, o_hv_reduced_state, o_tick, o_door_stop;
    logic        o_ilimit_evt;
    logic [7:0]  o_ctrl_norm, o_ctrl_prot, o_mux_sel;
    logic [15:0] o_cpu_rdata, o_mem_addr, o_mem_wdata;
    int          err_total = 0, comparisons = 0, k;
    always #50 i_mclk = ~i_mclk;
    dcg_top #(.P_TICK_CYC(20)) dcg_top_i (.*);
    dcg_host_model dcg_host_model_i (.i_mclk, .o_cmd_valid(i_cmd_valid), .o_cmd_word(i_cmd_word));
    function automatic logic [15:0] phd_addr(input logic s, input logic [6:0] h);
        return {7'h31, s, h, 1'b0};
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("Error %0t: %h != %h", $time, got, exp);
        end
    endtask
    task automatic cpu_wr(input logic [15:0] a, input logic [15:0] v);
        @(posedge i_mclk);
        i_cpu_addr  <= a;
        i_cpu_wdata <= v;
        i_cpu_wr    <= 1'b1;
        @(posedge i_mclk);
        i_cpu_wr    <= 1'b0;
    endtask
    task automatic cpu_rd(input logic [15:0] a, output logic [15:0] q);
        @(posedge i_mclk);
        i_cpu_addr <= a;
        i_cpu_rd   <= 1'b1;
        @(posedge i_mclk);
        i_cpu_rd   <= 1'b0;
        @(posedge i_mclk);
        #1;
        q = o_cpu_rdata;
        chk(16'(o_cpu_rvalid), 16'h1);
    endtask
    // Mask: ph_valid, dig[1:0], fast[1:0]
    task automatic hit(input logic [4:0] m, input int n);
        repeat (n) begin
            @(posedge i_mclk);
            {i_ph_valid, i_evt_dig, i_evt_fast} <= m;
            @(posedge i_mclk);
            {i_ph_valid, i_evt_dig, i_evt_fast} <= 5'h00;
        end
    endtask
    task automatic tally_and_finish;
        $display("Checks %0d errors %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge i_mclk);
        err_total++;
        tally_and_finish();
    end
    initial begin
        void'($urandom(53693));
        repeat (2) @(posedge i_mclk);
        i_rst <= 1'b0;
        @(posedge i_mclk);
        #1;
        chk(16'(o_cpu_reset), 16'h1);
        repeat (16) @(posedge i_mclk);
        #1;
        chk(16'(o_cpu_reset), 16'h0);
        for (int n = 0; n < 8; n++) begin
            w = $urandom;
            w[31:16] = (n == 0) ? 16'h1FFF : (n == 1) ? 16'h2000 : w[31:16] >> (n[0] * 3);
            dcg_host_model_i.send(w);
            #1;
            chk(16'(o_cmd_irq), 16'h1);
            chk(16'({o_mem_we, o_cmd_special}), (w[31:16] <= 16'h1FFF) ? 16'h2 : 16'h1);
        end
        cpu_rd(16'h4800, d);
        chk(d, w[31:16]);
        chk(16'(o_cmd_irq), 16'h0);
        $display("commands done");
        for (int c = 0; c < 4; c++) begin
            k = 1 + $urandom % 9;
            hit(c[0] ? (5'h04 << c[1]) : (5'h01 << c[1]), k);
            cpu_rd({7'h30, c[1], 6'h00, c[0], 1'b0}, d);
            chk(d, 16'(k));
            cpu_rd({7'h30, c[1], 6'h00, c[0], 1'b0}, d);
            chk(d, 16'h0);
        end
        $display("counters done");
        for (int s = 0; s < 2; s++) begin
            k = 1 + $urandom % 9;
            i_ph_seg    <= s[0];
            i_ph_height <= s[0] ? 7'h7F : 7'($urandom);
            hit(5'h10, k);
            cpu_rd(phd_addr(s[0], i_ph_height), d);
            chk(d, 16'(k));
            cpu_rd(phd_addr(!s[0], i_ph_height), d);
            chk(d, 16'h0);
            i_ph_disable <= 1'b1;
            cpu_wr(phd_addr(s[0], i_ph_height), 16'h0);
            cpu_rd(phd_addr(s[0], i_ph_height), d);
            i_ph_disable <= 1'b0;
            chk(d, 16'h0);
        end
        $display("histograms done");
        cpu_wr(16'h4200, 16'h001F);
        cpu_rd(16'h4200, d);
        chk(d, 16'h0);
        cpu_wr(16'h4500, 16'h0002);
        for (int t = 0; t < 2; t++) begin
            i_lock <= 1'b1;
            cpu_wr(16'h4200, 16'h0006);
            i_lock <= 1'b0;
            if (t == 0) i_door_latch <= 1'b1;
            else repeat (100) @(posedge i_mclk);
            cpu_rd(16'h4200, d);
            chk(d, 16'h0002);
        end
        $display("controls done");
        cpu_wr(16'h4300, 16'h0001);
        cpu_wr(16'h4400, 16'h0001);
        cpu_wr(16'h4100, 16'h0001);
        hit(5'h03, 40);
        chk(16'(o_hv_reduced_state), 16'h0001);
        cpu_wr(16'h4100, 16'h0002);
        i_lock <= 1'b1;
        cpu_wr(16'h4200, 16'h0013);
        i_lock <= 1'b0;
        i_ilimit <= 1'b1;
        repeat (3) @(posedge i_mclk);
        #1;
        chk(16'(o_ctrl_prot & 8'h11), 16'h0);
        i_ilimit <= 1'b0;
        cpu_wr(16'h4600, {8'h00, w[7:0]});
        cpu_rd(16'h4000, d);
        chk(16'(d[9]), 16'h1);
        repeat (110) @(posedge i_mclk);
        cpu_rd(16'h4000, d);
        chk(16'(d[9]), 16'h0);
        chk(16'(o_mux_sel), {8'h00, w[7:0]});
        i_main_reentry <= 1'b1;
        cpu_wr(16'hC000, w[15:0]);
        i_main_reentry <= 1'b0;
        i_cpu_fetch <= 1'b1;
        cpu_wr(16'h8000 | w[15:0], 16'h0000);
        i_cpu_fetch <= 1'b0;
        $display("protection test done");
        tally_and_finish();
    end
endmodule
bind dcg_top dcg_props #(.P_TICK_CYC(P_TICK_CYC)) dcg_props_i (.*);
